// *** design/ebdd_engine.sv ***
// ebdd_engine: walks transmit and receive descriptor lists in memory
// assumes a memory port that never stalls and answers reads one cycle
// after the read strobe; the receive stream comes from MAC logic on
// the same clock
`timescale 1ns/100ps
`default_nettype none

// Operation
// - tx abort sets teardown flag on SOP
// - only first unsent packet flagged, then stop
// - passthrough set: no FCS, length includes it
// - passthrough clear: append 4-byte FCS
// - descriptor is four aligned 32-bit words
// - null next ends queue; next never written
// - follow new link, else halt on null
// - nonzero offset shifts data, recorded in field
// - offset applies to first buffer only
// - buffer length rewritten with bytes stored
// - packet length written on SOP descriptor
// - set first and last packet flags
// - ownership cleared on SOP after last
// - last buffer at null next: queue end, halt
// - rx passthrough flag when FCS stored
// - rx teardown flags first free buffer
// - fcs, alignment, symbol, fragment, oversize, jabber flags only when errors kept
module ebdd_engine
    import ebdd_pkg::*;
(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA,
    // memory master
    output var ebdd_mem_t O_MEM,
    input wire logic [31:0] I_MEM_RDATA,
    // receive byte stream
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_LAST,
    input wire logic [9:0] I_RX_STATUS,
    input wire logic I_RX_FCS_KEPT,
    output logic O_RX_READY,
    // transmit packet hand-off
    output logic O_TX_START,
    output logic O_TX_FCS_APPEND,
    output logic [31:0] O_TX_BUF_PTR,
    output logic [15:0] O_TX_LEN,
    input wire logic I_TX_DONE
);

    ebdd_ctl_t ctl;
    ebdd_sts_t sts;

    ebdd_regs u_regs (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_addr(I_REG_ADDR),
        .i_wdata(I_REG_WDATA),
        .i_wr(I_REG_WR),
        .i_rd(I_REG_RD),
        .o_rdata(O_REG_RDATA),
        .i_sts(sts),
        .o_ctl(ctl)
    );

    ////////////////////////////////////////////////////////////////////
    // state

    ebdd_state_t st_q, st_d, ret_q, ret_d;
    ebdd_mem_t mem_q, mem_d;
    logic rdy_q, rdy_d;
    logic [31:0] rx_head_q, rx_head_d, sop_q, sop_d, buf_q, buf_d, nxt_q, nxt_d;
    logic [15:0] blen_q, blen_d, off_q, off_d, cnt_q, cnt_d, pkt_q, pkt_d;
    logic first_q, first_d, last_q, last_d, ovr_q, ovr_d, fcs_q, fcs_d;
    logic [9:0] stat_q, stat_d;
    logic rx_halt_q, rx_halt_d, rx_td_q, rx_td_d, tx_td_q, tx_td_d;
    logic [31:0] tx_head_q, tx_head_d, txf_q, txf_d;
    logic tx_halt_q, tx_halt_d;
    logic start_q, start_d, app_q, app_d;
    logic [31:0] txbuf_q, txbuf_d;
    logic [15:0] txlen_q, txlen_d;
    logic rx_td_clr, tx_td_clr, acc;
    logic [31:0] baddr;
    logic [9:0] stat_eff;

    function automatic ebdd_mem_t mem_read(input logic [31:0] a);
        ebdd_mem_t m;
        m = '0;
        m.rd = 1'b1;
        m.addr = a;
        return m;
    endfunction : mem_read

    function automatic ebdd_mem_t mem_write(input logic [31:0] a,
                                            input logic [31:0] d);
        ebdd_mem_t m;
        m = '0;
        m.wr = 1'b1;
        m.addr = a;
        m.wdata = d;
        m.be = WORD_LANES;
        return m;
    endfunction : mem_write

    assign acc = I_RX_VALID && rdy_q;
    assign baddr = buf_q + {16'h0, off_q} + {16'h0, cnt_q};
    // errors of discarded classes never reach the descriptor
    assign stat_eff = (ctl.keep_err ? stat_q : (stat_q & ~KEEP_GATED_ERRORS))
                    | (ovr_q ? OVERRUN_MASK : 10'h0);
    assign sts = '{rx_halt: rx_halt_q, tx_halt: tx_halt_q,
                   rx_td_pend: rx_td_q, tx_td_pend: tx_td_q};

    ////////////////////////////////////////////////////////////////////
    // descriptor engine

    always_comb
    begin
        st_d = st_q;
        ret_d = ret_q;
        mem_d = '0;
        rx_head_d = rx_head_q;
        sop_d = sop_q;
        buf_d = buf_q;
        nxt_d = nxt_q;
        blen_d = blen_q;
        off_d = off_q;
        cnt_d = cnt_q;
        pkt_d = pkt_q;
        first_d = first_q;
        last_d = last_q;
        ovr_d = ovr_q;
        fcs_d = fcs_q;
        stat_d = stat_q;
        rx_halt_d = rx_halt_q;
        tx_head_d = tx_head_q;
        tx_halt_d = tx_halt_q;
        txf_d = txf_q;
        start_d = 1'b0;
        app_d = app_q;
        txbuf_d = txbuf_q;
        txlen_d = txlen_q;
        rx_td_clr = 1'b0;
        tx_td_clr = 1'b0;
        // a head write restarts a halted channel
        if (ctl.rx_head_wr)
        begin
            rx_head_d = ctl.head;
            rx_halt_d = 1'b0;
        end
        if (ctl.tx_head_wr)
        begin
            tx_head_d = ctl.head;
            tx_halt_d = 1'b0;
        end
        unique case (st_q)
            S_IDLE:
            begin
                if (rx_td_q)
                begin
                    rx_td_clr = 1'b1;
                    rx_halt_d = 1'b1;
                    if (!rx_halt_q && rx_head_q != NULL_PTR)
                        mem_d = mem_write(rx_head_q + DESC_FLAGS_OFS,
                                          TEARDOWN_DONE_FLAG);
                end
                else if (I_RX_VALID && !rx_halt_q && rx_head_q != NULL_PTR)
                begin
                    sop_d = rx_head_q;
                    first_d = 1'b1;
                    last_d = 1'b0;
                    ovr_d = 1'b0;
                    pkt_d = '0;
                    mem_d = mem_read(rx_head_q + DESC_BUF_OFS);
                    ret_d = S_RX_GOT_BUF;
                    st_d = S_WAIT;
                end
                else if (tx_td_q && (tx_halt_q || tx_head_q == NULL_PTR))
                begin
                    tx_td_clr = 1'b1;
                    tx_halt_d = 1'b1;
                end
                else if (!tx_halt_q && tx_head_q != NULL_PTR)
                begin
                    mem_d = mem_read(tx_head_q + DESC_FLAGS_OFS);
                    ret_d = S_TX_GOT_FLAGS;
                    st_d = S_WAIT;
                end
            end
            S_WAIT:
                st_d = ret_q;
            S_RX_GOT_BUF:
            begin
                buf_d = I_MEM_RDATA;
                mem_d = mem_read(rx_head_q + DESC_LEN_OFS);
                ret_d = S_RX_GOT_LEN;
                st_d = S_WAIT;
            end
            S_RX_GOT_LEN:
            begin
                blen_d = I_MEM_RDATA[15:0];
                off_d = first_q ? ctl.offset : 16'h0;
                cnt_d = '0;
                st_d = S_RX_DATA;
            end
            S_RX_DATA:
            begin
                if (acc)
                begin
                    mem_d.wr = 1'b1;
                    mem_d.addr = {baddr[31:2], 2'b00};
                    mem_d.be = BYTE_LANE0 << baddr[1:0];
                    mem_d.wdata = {4{I_RX_DATA}};
                    cnt_d = cnt_q + 16'h1;
                    pkt_d = pkt_q + 16'h1;
                    if (I_RX_LAST)
                    begin
                        last_d = 1'b1;
                        stat_d = I_RX_STATUS;
                        fcs_d = I_RX_FCS_KEPT;
                        st_d = S_RX_NEXT;
                    end
                    else if ({16'h0, off_q} + {16'h0, cnt_q} + 32'h1
                             >= {16'h0, blen_q})
                        st_d = S_RX_NEXT;
                end
            end
            S_RX_DRAIN:
            begin
                // no buffer left: bytes are discarded up to the frame end
                if (acc && I_RX_LAST)
                begin
                    last_d = 1'b1;
                    stat_d = I_RX_STATUS;
                    fcs_d = I_RX_FCS_KEPT;
                    st_d = S_RX_WR_LEN;
                end
            end
            S_RX_NEXT:
            begin
                // read late so a freshly appended link is still seen
                mem_d = mem_read(rx_head_q + DESC_NEXT_OFS);
                ret_d = S_RX_GOT_NEXT;
                st_d = S_WAIT;
            end
            S_RX_GOT_NEXT:
            begin
                nxt_d = I_MEM_RDATA;
                if (!last_q && I_MEM_RDATA == NULL_PTR)
                begin
                    ovr_d = 1'b1;
                    st_d = S_RX_DRAIN;
                end
                else
                    st_d = S_RX_WR_LEN;
            end
            S_RX_WR_LEN:
            begin
                mem_d = mem_write(rx_head_q + DESC_LEN_OFS,
                                  {off_q, cnt_q});
                st_d = S_RX_WR_FLAGS;
            end
            S_RX_WR_FLAGS:
            begin
                // the first buffer's flag word waits so ownership goes last
                if (!first_q)
                    mem_d = mem_write(rx_head_q + DESC_FLAGS_OFS,
                        (last_q ? PACKET_LAST_FLAG : 32'h0)
                        | ((last_q && nxt_q == NULL_PTR) ? QUEUE_END_FLAG
                                                         : 32'h0));
                st_d = last_q ? S_RX_WR_SOP : S_RX_ADV;
            end
            S_RX_WR_SOP:
            begin
                mem_d = mem_write(sop_q + DESC_FLAGS_OFS,
                    PACKET_FIRST_FLAG
                    | (first_q ? PACKET_LAST_FLAG : 32'h0)
                    | ((first_q && nxt_q == NULL_PTR) ? QUEUE_END_FLAG : 32'h0)
                    | (fcs_q ? FCS_PASSTHROUGH_FLAG : 32'h0)
                    | {6'h0, stat_eff, pkt_q});
                st_d = S_RX_ADV;
            end
            S_RX_ADV:
            begin
                rx_head_d = nxt_q;
                if (nxt_q == NULL_PTR)
                    rx_halt_d = 1'b1;
                if (last_q)
                    st_d = S_IDLE;
                else
                begin
                    first_d = 1'b0;
                    mem_d = mem_read(nxt_q + DESC_BUF_OFS);
                    ret_d = S_RX_GOT_BUF;
                    st_d = S_WAIT;
                end
            end
            S_TX_GOT_FLAGS:
            begin
                txf_d = I_MEM_RDATA;
                if (tx_td_q)
                begin
                    mem_d = mem_write(tx_head_q + DESC_FLAGS_OFS,
                                      I_MEM_RDATA | TEARDOWN_DONE_FLAG);
                    tx_td_clr = 1'b1;
                    tx_halt_d = 1'b1;
                    st_d = S_IDLE;
                end
                else if ((I_MEM_RDATA & HW_OWNS_FLAG) == 32'h0)
                begin
                    tx_halt_d = 1'b1;
                    st_d = S_IDLE;
                end
                else
                begin
                    mem_d = mem_read(tx_head_q + DESC_BUF_OFS);
                    ret_d = S_TX_GOT_BUF;
                    st_d = S_WAIT;
                end
            end
            S_TX_GOT_BUF:
            begin
                txbuf_d = I_MEM_RDATA;
                start_d = 1'b1;
                app_d = (txf_q & FCS_PASSTHROUGH_FLAG) == 32'h0;
                txlen_d = txf_q[15:0] + (app_d ? FCS_BYTES : 16'h0);
                st_d = S_TX_WAIT;
            end
            S_TX_WAIT:
            begin
                if (I_TX_DONE)
                begin
                    mem_d = mem_read(tx_head_q + DESC_NEXT_OFS);
                    ret_d = S_TX_GOT_NEXT;
                    st_d = S_WAIT;
                end
            end
            S_TX_GOT_NEXT:
            begin
                mem_d = mem_write(tx_head_q + DESC_FLAGS_OFS,
                    (txf_q & ~HW_OWNS_FLAG)
                    | ((I_MEM_RDATA == NULL_PTR) ? QUEUE_END_FLAG : 32'h0));
                tx_head_d = I_MEM_RDATA;
                if (I_MEM_RDATA == NULL_PTR)
                    tx_halt_d = 1'b1;
                st_d = S_IDLE;
            end
        endcase
        // a command landing with its own clear is kept
        rx_td_d = (rx_td_q && !rx_td_clr) || ctl.rx_td;
        tx_td_d = (tx_td_q && !tx_td_clr) || ctl.tx_td;
        rdy_d = st_d == S_RX_DRAIN || (st_d == S_RX_DATA && st_q != S_RX_DATA)
              || (st_q == S_RX_DATA && st_d == S_RX_DATA);
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
        begin
            st_q <= S_IDLE;
            ret_q <= S_IDLE;
            mem_q <= '0;
            rdy_q <= 1'b0;
            {rx_head_q, sop_q, buf_q, nxt_q} <= '0;
            {blen_q, off_q, cnt_q, pkt_q} <= '0;
            {first_q, last_q, ovr_q, fcs_q, stat_q} <= '0;
            {rx_halt_q, rx_td_q, tx_td_q, tx_halt_q} <= '0;
            {tx_head_q, txf_q, txbuf_q, txlen_q} <= '0;
            {start_q, app_q} <= '0;
        end
        else
        begin
            st_q <= st_d;
            ret_q <= ret_d;
            mem_q <= mem_d;
            rdy_q <= rdy_d;
            {rx_head_q, sop_q, buf_q, nxt_q} <= {rx_head_d, sop_d, buf_d, nxt_d};
            {blen_q, off_q, cnt_q, pkt_q} <= {blen_d, off_d, cnt_d, pkt_d};
            {first_q, last_q, ovr_q, fcs_q, stat_q} <=
                {first_d, last_d, ovr_d, fcs_d, stat_d};
            {rx_halt_q, rx_td_q, tx_td_q, tx_halt_q} <=
                {rx_halt_d, rx_td_d, tx_td_d, tx_halt_d};
            {tx_head_q, txf_q, txbuf_q, txlen_q} <=
                {tx_head_d, txf_d, txbuf_d, txlen_d};
            {start_q, app_q} <= {start_d, app_d};
        end
    end

    assign O_MEM = mem_q;
    assign O_RX_READY = rdy_q;
    assign O_TX_START = start_q;
    assign O_TX_FCS_APPEND = app_q;
    assign O_TX_BUF_PTR = txbuf_q;
    assign O_TX_LEN = txlen_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    AST_RX_OWN_LAST: assert property (
        st_q == S_RX_ADV && last_q |-> O_MEM.wr
        && O_MEM.addr == sop_q + DESC_FLAGS_OFS
        && (O_MEM.wdata & HW_OWNS_FLAG) == 32'h0
        && (O_MEM.wdata & PACKET_FIRST_FLAG) != 32'h0)
        else $error("sop flag word wrong at packet end");

    AST_RX_PKT_LEN: assert property (
        st_q == S_RX_ADV && last_q |-> O_MEM.wdata[15:0] == pkt_q)
        else $error("packet length not written on sop");

    AST_RX_ERR_GATE: assert property (
        st_q == S_RX_ADV && last_q && !ctl.keep_err
        |-> (O_MEM.wdata[25:16] & KEEP_GATED_ERRORS) == 10'h0)
        else $error("error flag written while errors discarded");

    AST_RX_FCS: assert property (
        st_q == S_RX_ADV && last_q
        |-> ((O_MEM.wdata & FCS_PASSTHROUGH_FLAG) != 32'h0) == fcs_q)
        else $error("rx passthrough flag mismatch");

    AST_RX_EOQ_HALT: assert property (
        st_q == S_RX_ADV && last_q && nxt_q == NULL_PTR
        |=> rx_halt_q && st_q == S_IDLE)
        else $error("channel not halted at queue end");

    AST_RX_OFFSET: assert property (
        st_q == S_RX_DATA |-> off_q == (first_q ? ctl.offset : 16'h0))
        else $error("offset applied to wrong buffer");

    AST_RX_BYTE_WR: assert property (
        acc && st_q == S_RX_DATA |=> O_MEM.wr && O_MEM.be != WORD_LANES
        && cnt_q == $past(cnt_q) + 16'h1)
        else $error("accepted byte not stored");

    AST_NEXT_KEPT: assert property (
        O_MEM.wr && O_MEM.be == WORD_LANES
        |-> O_MEM.addr != rx_head_q && O_MEM.addr != tx_head_q
        && O_MEM.addr != sop_q)
        else $error("next pointer word written");

    AST_RX_TD: assert property (
        st_q == S_IDLE && rx_td_q && !rx_halt_q && rx_head_q != NULL_PTR
        |=> O_MEM.wr && O_MEM.wdata == TEARDOWN_DONE_FLAG && rx_halt_q)
        else $error("rx teardown not recorded");

    AST_TX_TD: assert property (
        st_q == S_TX_GOT_FLAGS && tx_td_q
        |=> O_MEM.wr && (O_MEM.wdata & TEARDOWN_DONE_FLAG) != 32'h0
        && tx_halt_q ##1 !O_TX_START && tx_halt_q)
        else $error("tx teardown not recorded or halted");

    AST_TX_FCS: assert property (
        O_TX_START |-> O_TX_FCS_APPEND
        == ((txf_q & FCS_PASSTHROUGH_FLAG) == 32'h0)
        && O_TX_LEN == txf_q[15:0] + (O_TX_FCS_APPEND ? FCS_BYTES : 16'h0))
        else $error("tx fcs handling mismatch");

endmodule : ebdd_engine

`default_nettype wire

// *** design/ebdd_pkg.sv ***
// ebdd_pkg: constants and carrier types of the descriptor engine
// assumes 32-bit memory words and descriptors on word boundaries
package ebdd_pkg;

    // descriptor layout: four words, byte offsets from the base
    localparam logic [31:0] DESC_NEXT_OFS = 32'h0;
    localparam logic [31:0] DESC_BUF_OFS = 32'h4;
    localparam logic [31:0] DESC_LEN_OFS = 32'h8;
    localparam logic [31:0] DESC_FLAGS_OFS = 32'hC;
    localparam logic [31:0] NULL_PTR = 32'h0;

    // flag word bits
    localparam logic [31:0] PACKET_FIRST_FLAG = 32'h8000_0000;
    localparam logic [31:0] PACKET_LAST_FLAG = 32'h4000_0000;
    localparam logic [31:0] HW_OWNS_FLAG = 32'h2000_0000;
    localparam logic [31:0] QUEUE_END_FLAG = 32'h1000_0000;
    localparam logic [31:0] TEARDOWN_DONE_FLAG = 32'h0800_0000;
    localparam logic [31:0] FCS_PASSTHROUGH_FLAG = 32'h0400_0000;

    // status: jabber, oversize, fragment, undersized, control,
    // overrun, symbol, alignment, fcs, address miss (bit 9 down to 0)
    localparam int STATUS_LSB = 16;
    localparam logic [9:0] KEEP_GATED_ERRORS = 10'h38E;
    localparam logic [9:0] OVERRUN_MASK = 10'h010;
    localparam logic [15:0] FCS_BYTES = 16'h4;
    localparam logic [3:0] BYTE_LANE0 = 4'h1;
    localparam logic [3:0] WORD_LANES = 4'hF;

    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RX_HEAD = 8'h04;
    localparam logic [7:0] REG_TX_HEAD = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_KEEP_ERR_BIT = 16;
    localparam int CMD_RX_TD_BIT = 0;
    localparam int CMD_TX_TD_BIT = 1;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } ebdd_mem_t;

    typedef struct packed {
        logic rx_td;
        logic tx_td;
        logic rx_head_wr;
        logic tx_head_wr;
        logic [31:0] head;
        logic [15:0] offset;
        logic keep_err;
    } ebdd_ctl_t;

    typedef struct packed {
        logic rx_halt;
        logic tx_halt;
        logic rx_td_pend;
        logic tx_td_pend;
    } ebdd_sts_t;

    typedef enum logic [4:0] {
        S_IDLE, S_WAIT,
        S_RX_GOT_BUF, S_RX_GOT_LEN, S_RX_DATA, S_RX_DRAIN, S_RX_NEXT,
        S_RX_GOT_NEXT, S_RX_WR_LEN, S_RX_WR_FLAGS, S_RX_WR_SOP, S_RX_ADV,
        S_TX_GOT_FLAGS, S_TX_GOT_BUF, S_TX_WAIT, S_TX_GOT_NEXT
    } ebdd_state_t;

endpackage : ebdd_pkg

// *** design/ebdd_regs.sv ***
// ebdd_regs: software register port of the descriptor engine
// assumes one-cycle strobes and read data expected the cycle after
`timescale 1ns/100ps
`default_nettype none

module ebdd_regs
    import ebdd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // engine side
    input wire ebdd_sts_t i_sts,
    output ebdd_ctl_t o_ctl
);

    logic [16:0] ctrl_q;
    logic [16:0] ctrl_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb
    begin
        ctrl_d = ctrl_q;
        rdata_d = '0;
        if (i_wr && i_addr == REG_CTRL)
            ctrl_d = i_wdata[16:0];
        // unmapped and write-only offsets read as zero
        if (i_rd)
        begin
            unique case (i_addr)
                REG_CTRL: rdata_d = {15'h0, ctrl_q};
                REG_STATUS: rdata_d = {28'h0, i_sts};
                default: rdata_d = '0;
            endcase
        end
        o_ctl.offset = ctrl_q[15:0];
        o_ctl.keep_err = ctrl_q[CTRL_KEEP_ERR_BIT];
        o_ctl.head = i_wdata;
        o_ctl.rx_head_wr = i_wr && i_addr == REG_RX_HEAD;
        o_ctl.tx_head_wr = i_wr && i_addr == REG_TX_HEAD;
        o_ctl.rx_td = i_wr && i_addr == REG_CMD && i_wdata[CMD_RX_TD_BIT];
        o_ctl.tx_td = i_wr && i_addr == REG_CMD && i_wdata[CMD_TX_TD_BIT];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

endmodule : ebdd_regs

`default_nettype wire

// *** testbench/ebdd_mem_model.sv ***
// ebdd_mem_model: system memory holding descriptors and buffers
// assumes reads answered the cycle after the strobe, no wait states
`timescale 1ns/100ps
`default_nettype none

module ebdd_mem_model
    import ebdd_pkg::*;
(
    // clock
    input wire logic i_clk,
    // memory port
    input wire ebdd_mem_t i_mem,
    output var logic [31:0] o_rdata
);
    logic [31:0] mem [0:255];

    initial
    begin
        o_rdata = 32'h0;
        for (int i = 0; i < 256; i++)
            mem[i] = 32'h0;
    end

    // data not held past its cycle: inverted, never stale
    always @(posedge i_clk)
    begin
        o_rdata <= ~o_rdata;
        if (i_mem.rd)
            o_rdata <= mem[i_mem.addr[9:2]];
        if (i_mem.wr)
            for (int b = 0; b < 4; b++)
                if (i_mem.be[b])
                    mem[i_mem.addr[9:2]][8*b+:8] <= i_mem.wdata[8*b+:8];
    end
endmodule : ebdd_mem_model

`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top: drives registers, rx stream and tx hand-off, judges memory
// assumes the memory model answers every read the next cycle
`timescale 1ns/100ps
`default_nettype none
`define M(a) mem_u.mem[(a)>>2]
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
    import ebdd_pkg::*;
    logic clk, rst, wr, rd, rv, rl, fk, td, rr;
    logic [7:0] ad, rdt;
    logic [31:0] wd, rq, mr, v;
    logic [9:0] st;
    ebdd_mem_t mm;
    logic ts, fa;
    logic [31:0] bp;
    logic [15:0] tl;
    int n_mismatch, n_compared, n_start;

    ebdd_engine dut_u (.I_CLOCK(clk), .I_SYS_RST(rst), .I_REG_ADDR(ad), .I_REG_WDATA(wd),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rq), .O_MEM(mm), .I_MEM_RDATA(mr),
        .I_RX_VALID(rv), .I_RX_DATA(rdt), .I_RX_LAST(rl), .I_RX_STATUS(st),
        .I_RX_FCS_KEPT(fk), .O_RX_READY(rr), .O_TX_START(ts), .O_TX_FCS_APPEND(fa),
        .O_TX_BUF_PTR(bp), .O_TX_LEN(tl), .I_TX_DONE(td));
    ebdd_mem_model mem_u (.i_clk(clk), .i_mem(mm), .o_rdata(mr));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // counted mid-cycle so the one-cycle pulse is seen exactly once
    always @(negedge clk)
        if (ts === 1'b1)
            n_start++;

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // an edge apart so two writes never drive the strobe in one step
        @(posedge clk);
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rq;
        @(posedge clk);
    endtask : rreg

    // polls status until the given halt bit shows, bounded
    task automatic wait_halt(input int b);
        for (int i = 0; i < 300; i++)
        begin
            rreg(REG_STATUS, v);
            if (v[b] === 1'b1)
                break;
        end
        if (v[b] !== 1'b1)
            n_mismatch++;
    endtask : wait_halt

    task automatic rx_pkt(input int n, input logic [9:0] s, input logic f);
        logic r;
        for (int i = 0; i < n; i++)
        begin
            rv <= 1'b1;
            rdt <= 8'hA0 + 8'(i);
            rl <= (i == n - 1);
            st <= s;
            fk <= f;
            // ready taken mid-cycle: the value the accepting edge uses
            do
            begin
                @(negedge clk);
                r = rr;
                @(posedge clk);
            end
            while (r !== 1'b1);
        end
        rv <= 1'b0;
        rl <= 1'b0;
    endtask : rx_pkt

    task automatic tx_wait(input logic e_fa, input logic [15:0] e_len, input logic [31:0] e_bp);
        for (int i = 0; i < 100 && ts !== 1'b1; i++)
            @(posedge clk) #1;
        if (ts !== 1'b1)
            n_mismatch++;
        `CHK(fa, e_fa)
        `CHK(tl, e_len)
        `CHK(bp, e_bp)
        @(posedge clk);
    endtask : tx_wait

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    task automatic test_regs;
        rreg(REG_STATUS, v);
        `CHK(v, 32'h0)
        rreg(8'hFC, v);
        `CHK(v, 32'h0)
        $display("test regs done");
    endtask : test_regs

    task automatic test_rx_single;
        // software: zeroed offset and flags, 0x40 buffer length, hw_owns_flag set, null end
        `M(32'h104) = 32'h200; `M(32'h108) = 32'h40; `M(32'h10C) = HW_OWNS_FLAG;
        wreg(REG_CTRL, 32'h0000_0003);
        wreg(REG_RX_HEAD, 32'h100);
        rx_pkt(5, 10'h38F, 1'b0);
        wait_halt(3);
        `CHK(`M(32'h100), 32'h0)
        `CHK(`M(32'h108), 32'h0003_0005)
        `CHK(`M(32'h10C), 32'hD001_0005)
        `CHK(`M(32'h200) >> 24, 32'hA0)
        `CHK(`M(32'h204) & 32'hFF, 32'hA1)
        $display("test rx single done");
    endtask : test_rx_single

    task automatic test_rx_multi;
        // links set before queuing, never touched while active
        `M(32'h110) = 32'h120; `M(32'h114) = 32'h240; `M(32'h118) = 32'h4;
        `M(32'h11C) = HW_OWNS_FLAG;
        `M(32'h124) = 32'h280; `M(32'h128) = 32'h40; `M(32'h12C) = HW_OWNS_FLAG;
        wreg(REG_CTRL, 32'h0001_0000);
        wreg(REG_RX_HEAD, 32'h110);
        rx_pkt(6, 10'h38F, 1'b1);
        wait_halt(3);
        `CHK(`M(32'h110), 32'h120)
        `CHK(`M(32'h118), 32'h0000_0004)
        `CHK(`M(32'h11C), 32'h878F_0006)
        `CHK(`M(32'h128), 32'h0000_0002)
        `CHK(`M(32'h12C), 32'h5000_0000)
        `CHK(`M(32'h280) & 32'hFF, 32'hA4)
        $display("test rx multi done");
    endtask : test_rx_multi

    task automatic test_rx_teardown;
        `M(32'h13C) = HW_OWNS_FLAG;
        wreg(REG_RX_HEAD, 32'h130);
        wreg(REG_CMD, 32'h1);
        wait_halt(3);
        `CHK(`M(32'h13C), 32'h0800_0000)
        $display("test rx teardown done");
    endtask : test_rx_teardown

    task automatic test_tx;
        `M(32'h140) = 32'h150; `M(32'h144) = 32'h300; `M(32'h14C) = 32'hE000_0014;
        `M(32'h150) = 32'h160; `M(32'h154) = 32'h340; `M(32'h15C) = 32'hE400_0020;
        `M(32'h160) = 32'h170; `M(32'h16C) = 32'hE000_0008; `M(32'h17C) = 32'hE000_0004;
        wreg(REG_TX_HEAD, 32'h140);
        tx_wait(1'b1, 16'h18, 32'h300);
        td <= 1'b1;
        @(posedge clk);
        td <= 1'b0;
        tx_wait(1'b0, 16'h20, 32'h340);
        wreg(REG_CMD, 32'h2);
        td <= 1'b1;
        @(posedge clk);
        td <= 1'b0;
        wait_halt(2);
        `CHK(`M(32'h14C), 32'hC000_0014)
        `CHK(`M(32'h16C), 32'hE800_0008)
        `CHK(`M(32'h17C), 32'hE000_0004)
        `CHK(n_start, 2)
        $display("test tx done");
    endtask : test_tx

    initial
    begin
        {rst, wr, rd, rv, rl, fk, td, ad, rdt, wd, st} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_regs();
        test_rx_single();
        test_rx_multi();
        test_rx_teardown();
        test_tx();
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
